/* File: eep_pkg.sv */
package eep_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int REG_W = 8;
	localparam int DIV_W = 10;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 16'h00ee;
	localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 16'h00ef;
	localparam logic [ADDR_W-1:0] OFS_MODULE_CFG = 16'h00f0;
	localparam logic [ADDR_W-1:0] OFS_BLOCK_PROT = 16'h00f1;
	localparam logic [ADDR_W-1:0] OFS_PROG_CTRL = 16'h00f3;

	// array window, shadow word and protected blocks (index 4 leftmost)
	localparam logic [ADDR_W-1:0] ARRAY_FIRST = 16'h0c00;
	localparam logic [ADDR_W-1:0] ARRAY_LAST = 16'h0fff;
	localparam logic [ADDR_W-1:0] SHADOW_ADDR = 16'h0fc0;
	localparam int NUM_BLK = 5;
	localparam logic [NUM_BLK-1:0][ADDR_W-1:0] BLK_FIRST = {
		16'h0c00, 16'h0e00, 16'h0f00, 16'h0f80, 16'h0fc0};
	localparam logic [NUM_BLK-1:0][ADDR_W-1:0] BLK_LAST = {
		16'h0dff, 16'h0eff, 16'h0f7f, 16'h0fbf, 16'h0fff};

	// block protect register
	localparam int BP_SHADOW = 7;
	localparam logic [REG_W-1:0] BP_MASK = 8'h9f;
	localparam logic [REG_W-1:0] BP_RESET = 8'h80;

	// program control register
	localparam int PC_BULK = 7;
	localparam int PC_AUTO = 5;
	localparam int PC_BYTE = 4;
	localparam int PC_ROW = 3;
	localparam int PC_ERASE = 2;
	localparam int PC_LATCH = 1;
	localparam int PC_PGM = 0;
	localparam logic [REG_W-1:0] PC_MASK = 8'hbf;
	localparam logic [REG_W-1:0] PC_RESET = 8'h80;

	// module configuration register
	localparam int MC_DBG = 7;
	localparam int MC_SHADOW_DISABLE = 6;
	localparam int MC_TEST = 5;
	localparam int MC_FLASH = 4;
	localparam int MC_ONE = 3;
	localparam int MC_WAITSTOP = 2;
	localparam int MC_LOCK = 1;
	localparam int MC_DUMMY = 0;
	localparam logic [REG_W-1:0] MC_RESET = 8'h0c;

	// shadow word layout: high byte [15:8], low byte [7:0]
	localparam int SH_CFG_HI = 15;
	localparam int SH_CFG_LO = 12;
	localparam int SH_DIV_HI = 9;
	localparam logic [DIV_W-1:0] DIV_ZERO = 10'h000;
	localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;

	// timed period counted in self-time ticks, rounded up
	localparam int PROG_TIME_US = 10000;
	localparam int TICK_NS = 35000;
	localparam int PROG_TICKS = (PROG_TIME_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int TICK_CNT_W = 9;
	localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(PROG_TICKS - 1);

	typedef enum logic [1:0] {GR_BULK, GR_ROW, GR_BYTE} eep_gran_t;
	typedef enum {ST_IDLE, ST_RUN, ST_BLOCKED, ST_DONE} eep_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic word;
		logic wr;
		logic rd;
	} eep_bus_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic word;
		logic erase;
		eep_gran_t gran;
		logic hv;
		logic shadow_sel;
	} eep_array_t;

endpackage

/* File: eep_ctrl.sv */
`timescale 1ns/10ps
// Summary of operation
// - block protect writable only with program enable and protect lock clear
// - shadow protect set refuses program or erase of the shadow word
// - each set block protect bit stops modification of its block
// - bits 4..0 cover 0c00-0dff, 0e00-0eff, 0f00-0f7f, 0f80-0fbf, 0fc0-0fff
// - bulk guard resets set, blocks bulk and row erase, lock-gated writes
// - with auto shutdown, program enable clears itself after the cycle
// - byte/row bits select bulk, 32-byte row or byte/word erase
// - byte erase touches only the latched location, byte or aligned word
// - erase bit chooses erase, otherwise programming
// - control bits except program enable frozen while program enable set
// - latch bit write refused while program enable set or divider zero
// - program enable sets only with latch already set
// - protected target: no cycle, no automatic clear of program enable
// - array writes ignored and latches frozen while program enable set
// - shadow word mapped at 0fc0 when enabled, loaded after reset
// - shadow high byte loads config bits 7..4 and divider 9..8
// - divider takes only its first write after reset in normal mode
// - no cycle starts while the divider is zero
module eep_ctrl
	import eep_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire eep_bus_t i_bus,
	input wire logic i_special_mode_n,
	input wire logic [DATA_W-1:0] i_shadow_word,
	output logic [REG_W-1:0] o_rdata,
	output eep_array_t o_array,
	output logic o_done,
	output logic o_debug_lockout_disable,
	output logic o_flash_open,
	output logic o_wait_stop
);

	logic [REG_W-1:0] prot_r;
	logic [REG_W-1:0] prot_nxt;
	logic [REG_W-1:0] ctrl_r;
	logic [REG_W-1:0] ctrl_nxt;
	logic [REG_W-1:0] mcr_r;
	logic [REG_W-1:0] mcr_nxt;
	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_nxt;
	logic div_hi_lock_r;
	logic div_lo_lock_r;
	logic lock_once_r;
	logic boot_r;
	logic [ADDR_W-1:0] lat_addr_r;
	logic [DATA_W-1:0] lat_data_r;
	logic lat_word_r;
	eep_state_t state_r;
	eep_state_t state_nxt;
	logic [DIV_W-1:0] pres_r;
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic [REG_W-1:0] rdata_r;

	// range test used for block and array decode
	function automatic logic in_range(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic blk_locked(input logic [ADDR_W-1:0] a,
		input logic [NUM_BLK-1:0] bp);
		blk_locked = 1'b0;
		for (int i = 0; i < NUM_BLK; i++) begin
			if (bp[i] && in_range(a, BLK_FIRST[i], BLK_LAST[i])) begin
				blk_locked = 1'b1;
			end
		end
	endfunction

	// bus decode
	wire pgm = ctrl_r[PC_PGM];
	wire latch = ctrl_r[PC_LATCH];
	wire special = !i_special_mode_n;
	wire div_zero = (div_r == DIV_ZERO);
	wire wr_prot = i_bus.wr && (i_bus.addr == OFS_BLOCK_PROT);
	wire wr_ctrl = i_bus.wr && (i_bus.addr == OFS_PROG_CTRL);
	wire wr_mcr = i_bus.wr && (i_bus.addr == OFS_MODULE_CFG);
	wire wr_div_hi = i_bus.wr && (i_bus.addr == OFS_DIV_HIGH);
	wire wr_div_lo = i_bus.wr && (i_bus.addr == OFS_DIV_LOW);
	wire arr_hit = in_range(i_bus.addr, ARRAY_FIRST, ARRAY_LAST);
	wire wr_arr = i_bus.wr && arr_hit && latch && !pgm;
	wire [REG_W-1:0] wd = i_bus.wdata[REG_W-1:0];

	// protection check on the latched target
	wire shadow_on = !mcr_r[MC_SHADOW_DISABLE];
	wire shadow_hit = shadow_on &&
		(lat_addr_r[ADDR_W-1:1] == SHADOW_ADDR[ADDR_W-1:1]);
	wire erase = ctrl_r[PC_ERASE];
	eep_gran_t gran;
	assign gran = ctrl_r[PC_BYTE] ? GR_BYTE :
		(ctrl_r[PC_ROW] ? GR_ROW : GR_BULK);
	wire bulk_like = erase && (gran != GR_BYTE);
	wire any_blk = |prot_r[NUM_BLK-1:0];
	wire hit_blk = blk_locked(lat_addr_r, prot_r[NUM_BLK-1:0]);
	wire hit_shadow = shadow_hit && prot_r[BP_SHADOW];
	wire hit_bulk = bulk_like && ctrl_r[PC_BULK];
	// a bulk erase sweeps every block, so any locked block refuses it
	wire hit_whole = erase && (gran == GR_BULK) &&
		(any_blk || prot_r[BP_SHADOW]);
	wire refused = hit_blk || hit_shadow || hit_bulk || hit_whole;
	wire start_ok = !refused && !div_zero;

	// self-time prescaler and period counter
	wire running = (state_r == ST_RUN);
	wire tick = running && (pres_r == div_r - DIV_ONE);
	wire done = tick && (tick_cnt_r == TICK_LAST);
	wire auto_clr = done && ctrl_r[PC_AUTO];

	// next values of the block protect register
	wire prot_open = !pgm && !mcr_r[MC_LOCK];
	assign prot_nxt = (wr_prot && prot_open) ? (wd & BP_MASK) : prot_r;

	// next values of the program control register
	logic [REG_W-1:0] ctrl_wr;
	always_comb begin
		ctrl_wr = ctrl_r;
		if (pgm) begin
			ctrl_wr[PC_PGM] = wd[PC_PGM];
		end else begin
			if (!mcr_r[MC_LOCK]) begin
				ctrl_wr[PC_BULK] = wd[PC_BULK];
			end
			ctrl_wr[PC_AUTO] = wd[PC_AUTO];
			ctrl_wr[PC_BYTE] = wd[PC_BYTE];
			ctrl_wr[PC_ROW] = wd[PC_ROW];
			ctrl_wr[PC_ERASE] = wd[PC_ERASE];
			if (!div_zero) begin
				ctrl_wr[PC_LATCH] = wd[PC_LATCH];
			end
			// old latch value: setting both at once leaves enable clear
			ctrl_wr[PC_PGM] = wd[PC_PGM] && latch;
		end
	end

	always_comb begin
		ctrl_nxt = wr_ctrl ? (ctrl_wr & PC_MASK) : ctrl_r;
		if (auto_clr) begin
			ctrl_nxt[PC_PGM] = 1'b0;
		end
	end

	// module configuration: field-by-field write permissions
	always_comb begin
		mcr_nxt = mcr_r;
		if (wr_mcr) begin
			if (special) begin
				mcr_nxt[MC_DBG] = wd[MC_DBG];
				mcr_nxt[MC_SHADOW_DISABLE] = wd[MC_SHADOW_DISABLE];
				mcr_nxt[MC_TEST] = wd[MC_TEST];
				mcr_nxt[MC_FLASH] = wd[MC_FLASH];
				mcr_nxt[MC_LOCK] = wd[MC_LOCK];
			end else begin
				mcr_nxt[MC_FLASH] = mcr_r[MC_FLASH] && wd[MC_FLASH];
				if (!lock_once_r) begin
					mcr_nxt[MC_LOCK] = wd[MC_LOCK];
				end
			end
			mcr_nxt[MC_WAITSTOP] = wd[MC_WAITSTOP];
			mcr_nxt[MC_DUMMY] = wd[MC_DUMMY];
		end
		mcr_nxt[MC_ONE] = 1'b1;
		if (boot_r) begin
			mcr_nxt[MC_DBG:MC_FLASH] =
				i_shadow_word[SH_CFG_HI:SH_CFG_LO];
		end
	end

	// divider: write once in normal mode, never while latched
	wire div_open = !latch;
	wire div_hi_ok = wr_div_hi && div_open && (special || !div_hi_lock_r);
	wire div_lo_ok = wr_div_lo && div_open && (special || !div_lo_lock_r);
	always_comb begin
		div_nxt = div_r;
		if (div_hi_ok) begin
			div_nxt[DIV_W-1:REG_W] = wd[DIV_W-REG_W-1:0];
		end
		if (div_lo_ok) begin
			div_nxt[REG_W-1:0] = wd;
		end
		if (boot_r) begin
			div_nxt = i_shadow_word[SH_DIV_HI:0];
		end
	end

	// cycle sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (pgm) begin
					state_nxt = start_ok ? ST_RUN : ST_BLOCKED;
				end
			end
			ST_RUN: begin
				if (!pgm) begin
					state_nxt = ST_IDLE;
				end else if (done) begin
					state_nxt = ST_DONE;
				end
			end
			ST_BLOCKED, ST_DONE: begin
				if (!pgm) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// read data mux
	logic [REG_W-1:0] rd_val;
	always_comb begin
		rd_val = '0;
		unique case (i_bus.addr)
			OFS_BLOCK_PROT: rd_val = prot_r;
			OFS_PROG_CTRL: rd_val = ctrl_r;
			OFS_MODULE_CFG: rd_val = mcr_r;
			OFS_DIV_HIGH: rd_val = REG_W'(div_r[DIV_W-1:REG_W]);
			OFS_DIV_LOW: rd_val = div_r[REG_W-1:0];
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prot_r <= BP_RESET;
			ctrl_r <= PC_RESET;
			mcr_r <= MC_RESET;
			div_r <= DIV_ZERO;
			boot_r <= 1'b1;
		end else begin
			prot_r <= prot_nxt;
			ctrl_r <= ctrl_nxt;
			mcr_r <= mcr_nxt;
			div_r <= div_nxt;
			boot_r <= 1'b0;
		end
	end

	// write-once tracking in normal mode
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_hi_lock_r <= 1'b0;
			div_lo_lock_r <= 1'b0;
			lock_once_r <= 1'b0;
		end else begin
			div_hi_lock_r <= div_hi_lock_r || (div_hi_ok && !special);
			div_lo_lock_r <= div_lo_lock_r || (div_lo_ok && !special);
			lock_once_r <= lock_once_r || (wr_mcr && !special);
		end
	end

	// latches capture one target; word writes are forced aligned
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lat_addr_r <= '0;
			lat_data_r <= '0;
			lat_word_r <= 1'b0;
		end else if (wr_arr) begin
			lat_addr_r <= {i_bus.addr[ADDR_W-1:1],
				i_bus.addr[0] && !i_bus.word};
			lat_data_r <= i_bus.wdata;
			lat_word_r <= i_bus.word;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= ST_IDLE;
			pres_r <= DIV_ZERO;
			tick_cnt_r <= '0;
			rdata_r <= '0;
		end else begin
			state_r <= state_nxt;
			pres_r <= (!running || tick) ? DIV_ZERO : pres_r + DIV_ONE;
			if (!running) begin
				tick_cnt_r <= '0;
			end else if (tick) begin
				tick_cnt_r <= tick_cnt_r + TICK_CNT_W'(1);
			end
			rdata_r <= i_bus.rd ? rd_val : '0;
		end
	end

	assign o_rdata = rdata_r;
	assign o_done = done;
	assign o_array.addr = lat_addr_r;
	assign o_array.data = lat_data_r;
	assign o_array.word = lat_word_r;
	assign o_array.erase = erase;
	assign o_array.gran = gran;
	assign o_array.hv = running;
	assign o_array.shadow_sel = shadow_hit;
	assign o_debug_lockout_disable = mcr_r[MC_DBG];
	assign o_flash_open = mcr_r[MC_FLASH];
	assign o_wait_stop = mcr_r[MC_WAITSTOP];

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_prot_attempt;
		wr_prot && !prot_open;
	endsequence

	sequence s_both_set;
		wr_ctrl && !pgm && !latch && wd[PC_PGM] && wd[PC_LATCH] && !div_zero;
	endsequence

	a_prot_write_gate: assert property (
		s_prot_attempt |=> $stable(prot_r))
		else $error("block protect changed while locked");

	a_pgm_after_latch: assert property (
		s_both_set |=> latch && !pgm)
		else $error("enable set together with latch");

	a_pgm_needs_latch: assert property (
		$rose(pgm) |-> $past(latch))
		else $error("enable rose without latch");

	a_ctrl_frozen: assert property (
		pgm |=> ctrl_r[PC_BULK:PC_LATCH] ==
			$past(ctrl_r[PC_BULK:PC_LATCH]))
		else $error("control bits moved while enabled");

	a_latch_zero_div: assert property (
		div_zero && !latch |=> !latch)
		else $error("latch set with zero divider");

	a_zero_div_start: assert property (
		$rose(o_array.hv) |-> !div_zero)
		else $error("cycle started with zero divider");

	a_auto_shutdown: assert property (
		done && ctrl_r[PC_AUTO] |=> !pgm ##1 state_r == ST_IDLE)
		else $error("auto shutdown did not clear enable");

	a_blocked_holds: assert property (
		state_r == ST_BLOCKED && pgm && !wr_ctrl |=> pgm && !o_array.hv)
		else $error("refused cycle ran or cleared enable");

	a_latch_frozen: assert property (
		pgm |=> $stable(lat_addr_r) && $stable(lat_data_r))
		else $error("latched target changed while enabled");

	a_div_once: assert property (
		wr_div_lo && div_lo_lock_r && !special |=> $stable(div_r))
		else $error("divider rewritten in normal mode");

	a_shadow_guard: assert property (
		o_array.hv |-> !(shadow_hit && prot_r[BP_SHADOW]))
		else $error("protected shadow word modified");

	a_shadow_load: assert property (
		$fell(boot_r) |-> div_r == $past(i_shadow_word[SH_DIV_HI:0]))
		else $error("divider not loaded from shadow word");

	a_row_refused: assert property (
		state_r == ST_IDLE && pgm && hit_bulk |=> state_r == ST_BLOCKED)
		else $error("row or bulk erase started under bulk guard");

	a_block_refused: assert property (
		state_r == ST_IDLE && pgm && hit_blk |=> state_r == ST_BLOCKED)
		else $error("cycle started on a protected block");

endmodule

/* File: eep_array_model.sv */
`timescale 1ns/10ps
module eep_array_model
	import eep_pkg::*;
#(
	parameter logic [DATA_W-1:0] SHADOW_INIT = 16'h9c03
)(
	input wire logic i_sys_clk,
	input wire eep_array_t i_array,
	input wire logic i_done,
	output logic [DATA_W-1:0] o_shadow_word
);
	// nonvolatile: content survives every reset of the controller
	initial o_shadow_word = SHADOW_INIT;
	always @(posedge i_sys_clk) begin
		if (i_done && i_array.hv && i_array.shadow_sel) begin
			// programming only clears bits, erasing sets them all
			if (i_array.erase)
				o_shadow_word <= 16'hffff;
			else
				o_shadow_word <= o_shadow_word & i_array.data;
		end
	end
endmodule

/* File: tb_eep_ctrl.sv */
`timescale 1ns/10ps
module tb_eep_ctrl
	import eep_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic smode_n = 1'b1;
	eep_bus_t bus = '0;
	logic [REG_W-1:0] rdata;
	eep_array_t arr;
	logic done, dbg, fopen, wstop;
	logic [DATA_W-1:0] shw;
	int num_errors = 0;
	int cmp_count = 0;
	int hv_cnt = 0;
	int done_cnt = 0;

	always #20 i_sys_clk = ~i_sys_clk;

	eep_ctrl dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_bus(bus), .i_special_mode_n(smode_n), .i_shadow_word(shw),
		.o_rdata(rdata), .o_array(arr), .o_done(done),
		.o_debug_lockout_disable(dbg), .o_flash_open(fopen),
		.o_wait_stop(wstop));
	eep_array_model model (.i_sys_clk(i_sys_clk), .i_array(arr),
		.i_done(done), .o_shadow_word(shw));

	always @(posedge i_sys_clk) begin
		if (arr.hv === 1'b1)
			hv_cnt++;
		if (done === 1'b1)
			done_cnt++;
	end

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v,
		input logic w);
		@(posedge i_sys_clk);
		bus <= '{addr: a, wdata: v, word: w, wr: 1'b1, rd: 1'b0};
		@(posedge i_sys_clk);
		bus.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [15:0] a, output logic [REG_W-1:0] v);
		@(posedge i_sys_clk);
		bus <= '{addr: a, wdata: 16'h0000, word: 1'b0, wr: 1'b0, rd: 1'b1};
		@(posedge i_sys_clk);
		bus.rd <= 1'b0;
		// read data stands only in this one cycle
		#1 v = rdata;
	endtask

	task automatic rchk(input string nm, input logic [15:0] a,
		input logic [REG_W-1:0] exp);
		logic [REG_W-1:0] v;
		rd(a, v);
		chk(nm, 16'(v), 16'(exp));
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic poll_pgm();
		logic [REG_W-1:0] v;
		int n;
		v = 8'h01;
		// software view: poll the enable bit until the block clears it
		for (n = 0; n < 1000 && v[PC_PGM] !== 1'b0; n++)
			rd(OFS_PROG_CTRL, v);
		chk("enable cleared", 16'(v), 16'h0022);
	endtask

	task automatic do_reset();
		@(posedge i_sys_clk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		// first edge after release belongs to the shadow load
		cyc(2);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic t_reset_vals();
		rchk("block_protect", OFS_BLOCK_PROT, 8'h80);
		rchk("prog_control", OFS_PROG_CTRL, 8'h80);
		rchk("module_config", OFS_MODULE_CFG, 8'h9c);
		rchk("divider_high", OFS_DIV_HIGH, 8'h00);
		rchk("divider_low", OFS_DIV_LOW, 8'h03);
		rchk("unmapped", 16'h00ed, 8'h00);
		chk("debug_lockout", 16'(dbg), 16'h0001);
		chk("flash_open", 16'(fopen), 16'h0001);
		chk("wait_stop", 16'(wstop), 16'h0001);
	endtask

	task automatic t_div_once();
		// small divider keeps every timed period short
		wr(OFS_DIV_LOW, 16'h0002, 1'b0);
		wr(OFS_DIV_LOW, 16'h0007, 1'b0);
		rchk("divider once", OFS_DIV_LOW, 8'h02);
	endtask

	task automatic t_auto_prog();
		wr(OFS_PROG_CTRL, 16'h0023, 1'b0);
		rchk("latch before enable", OFS_PROG_CTRL, 8'h22);
		// odd address with a word write must come out aligned
		wr(16'h0c11, 16'h1234, 1'b1);
		chk("latched addr", arr.addr, 16'h0c10);
		chk("word size", 16'(arr.word), 16'h0001);
		wr(OFS_PROG_CTRL, 16'h0023, 1'b0);
		hv_cnt = 0;
		done_cnt = 0;
		cyc(2);
		chk("hv program", 16'(arr.hv), 16'h0001);
		chk("erase off", 16'(arr.erase), 16'h0000);
		wr(16'h0c20, 16'hffff, 1'b1);
		chk("frozen addr", arr.addr, 16'h0c10);
		chk("frozen data", arr.data, 16'h1234);
		wr(OFS_PROG_CTRL, 16'h0001, 1'b0);
		rchk("bits frozen", OFS_PROG_CTRL, 8'h23);
		poll_pgm();
		// divider of 2 set above: two clocks per self-time tick
		chk("period", 16'(hv_cnt), 16'(PROG_TICKS * 2));
		chk("one done", 16'(done_cnt), 16'h0001);
	endtask

	task automatic t_gran();
		logic [15:0] code[4] = '{16'h0004, 16'h000c, 16'h0014, 16'h001c};
		eep_gran_t g[4] = '{GR_BULK, GR_ROW, GR_BYTE, GR_BYTE};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PROG_CTRL, code[i], 1'b0);
			chk("granularity", 16'(arr.gran), 16'(g[i]));
			chk("erase on", 16'(arr.erase), 16'h0001);
		end
	endtask

	task automatic t_row_guard();
		wr(OFS_PROG_CTRL, 16'h00ae, 1'b0);
		wr(16'h0c00, 16'h00aa, 1'b0);
		wr(OFS_PROG_CTRL, 16'h00af, 1'b0);
		cyc(10);
		chk("row refused", 16'(arr.hv), 16'h0000);
		rchk("no auto clear", OFS_PROG_CTRL, 8'haf);
		wr(OFS_PROG_CTRL, 16'h00ae, 1'b0);
		wr(OFS_PROG_CTRL, 16'h0000, 1'b0);
	endtask

	task automatic t_blocks();
		logic [15:0] last[5] = '{16'h0fff, 16'h0fbf, 16'h0f7f, 16'h0eff,
			16'h0dff};
		for (int i = 0; i < 5; i++) begin
			wr(OFS_BLOCK_PROT, 16'(1 << i), 1'b0);
			wr(OFS_PROG_CTRL, 16'h0002, 1'b0);
			wr(last[i], 16'h0055, 1'b0);
			chk("byte addr", arr.addr, last[i]);
			chk("byte size", 16'(arr.word), 16'h0000);
			wr(OFS_PROG_CTRL, 16'h0003, 1'b0);
			cyc(4);
			chk("block refused", 16'(arr.hv), 16'h0000);
			wr(OFS_BLOCK_PROT, 16'h0000, 1'b0);
			rchk("protect held", OFS_BLOCK_PROT, 8'(1 << i));
			rchk("enable kept", OFS_PROG_CTRL, 8'h03);
			wr(OFS_PROG_CTRL, 16'h0002, 1'b0);
			wr(OFS_PROG_CTRL, 16'h0000, 1'b0);
		end
	endtask

	task automatic t_shadow();
		@(posedge i_sys_clk) smode_n <= 1'b0;
		wr(OFS_BLOCK_PROT, 16'h0080, 1'b0);
		wr(OFS_PROG_CTRL, 16'h0022, 1'b0);
		wr(SHADOW_ADDR, 16'h9c00, 1'b1);
		chk("shadow select", 16'(arr.shadow_sel), 16'h0001);
		wr(OFS_PROG_CTRL, 16'h0023, 1'b0);
		cyc(4);
		chk("shadow refused", 16'(arr.hv), 16'h0000);
		wr(OFS_PROG_CTRL, 16'h0022, 1'b0);
		wr(OFS_BLOCK_PROT, 16'h0000, 1'b0);
		wr(OFS_PROG_CTRL, 16'h0023, 1'b0);
		hv_cnt = 0;
		cyc(2);
		poll_pgm();
		chk("shadow modified", 16'(hv_cnt > 0), 16'h0001);
		wr(OFS_PROG_CTRL, 16'h0000, 1'b0);
		wr(OFS_BLOCK_PROT, 16'h0080, 1'b0);
		@(posedge i_sys_clk) smode_n <= 1'b1;
	endtask

	task automatic t_div_zero();
		// the shadow word now holds a zero divider
		do_reset();
		rchk("reload divider", OFS_DIV_LOW, 8'h00);
		rchk("reload config", OFS_MODULE_CFG, 8'h9c);
		wr(OFS_MODULE_CFG, 16'h0006, 1'b0);
		rchk("lock and flash", OFS_MODULE_CFG, 8'h8e);
		wr(OFS_BLOCK_PROT, 16'h0001, 1'b0);
		rchk("protect locked", OFS_BLOCK_PROT, 8'h80);
		wr(OFS_PROG_CTRL, 16'h0003, 1'b0);
		rchk("latch refused", OFS_PROG_CTRL, 8'h80);
		cyc(4);
		chk("no cycle", 16'(arr.hv), 16'h0000);
	endtask

	initial begin
		#(20000 * 40);
		num_errors++;
		close_out();
	end

	initial begin
		do_reset();
		t_reset_vals();
		t_div_once();
		t_auto_prog();
		t_gran();
		t_row_guard();
		t_blocks();
		t_shadow();
		t_div_zero();
		close_out();
	end
endmodule
